/* File: core/iosw_pkg.sv */
// Package for the internal oscillator select switch: register map, field
// layout, reset values, source encodings and timing constants.
// Assumes a 100 MHz register clock and a 32-bit AXI4-Lite register bus.
package iosw_pkg;

  // Register clock and timing
  localparam int unsigned REF_CLK_MHZ    = 100;
  localparam int unsigned STARTUP_NS     = 2000;  // Oscillator start-up wait
  localparam int unsigned STARTUP_CYC    =
    (STARTUP_NS * REF_CLK_MHZ + 999) / 1000;     // Least time, rounded up

  // Register byte addresses
  localparam logic [7:0] OSC_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] OSC_STAT_ADDR   = 8'h04;
  localparam int unsigned ADDR_W         = 8;

  // Control register fields
  localparam int unsigned CTRL_PLL_BIT   = 7;
  localparam int unsigned CTRL_FREQ_LSB  = 3;
  localparam int unsigned CTRL_SCS_LSB   = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h38;
  localparam logic [7:0]  CTRL_WR_MASK   = 8'hfb;  // Bit 2 reads as zero

  // Field codes
  localparam logic [2:0] FOSC_INT_BLOCK  = 3'h4;
  localparam logic [1:0] SCS_CFG_WORD    = 2'h0;
  localparam logic [1:0] SCS_TIMER_OSC   = 2'h1;
  localparam logic [3:0] FREQ_HF_16M     = 4'hf;
  localparam logic [3:0] FREQ_HF_8M      = 4'he;
  localparam logic [3:0] FREQ_HF_31K     = 4'h3;
  localparam logic [3:0] FREQ_MF_31K     = 4'h2;

  // Bus responses
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // Clock sources the switch can route
  typedef enum logic [2:0] {
    SRC_LF, SRC_MF, SRC_HF, SRC_PLL, SRC_TIMER, SRC_EXT
  } iosw_src_t;

  // Oscillator clock levels sampled on the register clock
  typedef struct packed {
    logic ext;
    logic timer;
    logic pll;
    logic hf;
    logic mf;
    logic lf;
  } iosw_osc_t;

  // Selection: routed source plus frequency code
  typedef struct packed {
    iosw_src_t  src;
    logic [3:0] freq;
  } iosw_sel_t;

endpackage : iosw_pkg

/* File: core/iosw_top.sv */
// Internal oscillator select switch with an AXI4-Lite register slave.
// Assumes oscillator clock levels arrive synchronous to ref_clk_i and that
// configuration-word settings are stable across reset release.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Config oscillator field 100 selects the internal oscillator block.
// - System select 00 uses the source chosen by the config word.
// - Frequency code 1110 picks 8 MHz high oscillator, feeding the PLL.
// - PLL is enabled by software bit or by the config PLL bit.
// - Config PLL forces PLL on; with select 00, plain 8 MHz no longer offered.
// - System select 1x never applies the PLL; only 00 allows it.
// - Code 1111 is 16 MHz, 1110 is 8/32 MHz, lower codes lower.
// - Select 1x internal block, 01 timer oscillator, 00 config word.
// - Changing frequency code runs a start-up delay if target was off; PLL counts as on while HF runs.
// - Switch waits for a falling edge of the current clock.
// - Then holds clock low until new clock rises, then switches.
// - Status register reports high, mid and low oscillator activity.
// - Status updates only once the new clock is active.
// - Changing frequency within one source applies no start-up delay.
module iosw_top
  import iosw_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = STARTUP_CYC
) (
  // Clock, reset, enable
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_en_i,
  // Configuration word
  input  wire logic [2:0]        cfg_osc_select_i,
  input  wire logic              cfg_pll_enable_i,
  // Oscillator clock levels
  input  wire iosw_osc_t         osc_level_i,
  // Clock outputs
  output logic                   sys_clk_o,
  output logic                   pll_enable_o,
  // AXI4-Lite write address and data
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  // AXI4-Lite read
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o
);

  // Elaboration check on the start-up count
  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin : g_chk
    $error("STARTUP_CYCLES must lie in 1..65535");
  end

  typedef enum logic [1:0] {ST_RUN, ST_STARTUP, ST_WAIT_FALL, ST_HOLD_LOW}
    iosw_state_t;

  // Switch state
  iosw_state_t state, next_state;
  iosw_sel_t   active_sel, next_active_sel;
  iosw_sel_t   target_sel;
  logic [15:0] wait_cnt, next_wait_cnt;
  logic [5:0]  osc_status, next_osc_status;
  logic        clk_out, next_clk_out;
  iosw_osc_t   osc_prev;
  logic [2:0]  cfg_osc;
  logic        cfg_pll, cfg_valid;
  logic        pll_on;
  logic        cur_level, new_level, cur_prev, new_prev;

  // Register state
  logic [7:0]  ctrl, next_ctrl;
  logic        aw_full, next_aw_full, w_full, next_w_full;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        awready, next_awready, wready, next_wready;
  logic        bvalid, next_bvalid, arready, next_arready;
  logic        rvalid, next_rvalid;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic        pll_out, next_pll_out;

  // Clock level of a source
  function automatic logic level_of(iosw_src_t s, iosw_osc_t o);
    logic l;
    l = 1'b0;
    unique case (s)
      SRC_LF:    l = o.lf;
      SRC_MF:    l = o.mf;
      SRC_HF:    l = o.hf;
      SRC_PLL:   l = o.pll;
      SRC_TIMER: l = o.timer;
      SRC_EXT:   l = o.ext;
      default:   l = 1'b0;
    endcase
    return l;
  endfunction : level_of

  // Frequency code to internal oscillator
  function automatic iosw_src_t freq_src(logic [3:0] f);
    iosw_src_t s;
    s = SRC_LF;
    if (f[3] || f == FREQ_HF_31K) begin
      s = SRC_HF;
    end else if (f[2] || f == FREQ_MF_31K) begin
      s = SRC_MF;
    end
    return s;
  endfunction : freq_src

  // Status bit position of a source
  function automatic logic [5:0] src_bit(iosw_src_t s);
    logic [5:0] b;
    b = 6'h00;
    b[s] = 1'b1;
    if (s == SRC_PLL) begin
      b[SRC_HF] = 1'b1;                             // PLL runs from HF
    end
    return b;
  endfunction : src_bit

  // Configuration word capture, once after reset release
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_osc   <= 3'h0;
      cfg_pll   <= 1'b0;
      cfg_valid <= 1'b0;
    end else if (clk_en_i && !cfg_valid) begin
      cfg_osc   <= cfg_osc_select_i;
      cfg_pll   <= cfg_pll_enable_i;
      cfg_valid <= 1'b1;
    end
  end

  // Target selection from control and configuration
  always_comb begin
    pll_on     = ctrl[CTRL_PLL_BIT] | cfg_pll;
    target_sel.freq = ctrl[CTRL_FREQ_LSB +: 4];
    target_sel.src  = freq_src(ctrl[CTRL_FREQ_LSB +: 4]);
    if (ctrl[CTRL_SCS_LSB + 1]) begin
      target_sel.src = freq_src(ctrl[CTRL_FREQ_LSB +: 4]);
    end else if (ctrl[CTRL_SCS_LSB +: 2] == SCS_TIMER_OSC) begin
      target_sel.src = SRC_TIMER;
    end else if (cfg_osc != FOSC_INT_BLOCK) begin
      target_sel.src = SRC_EXT;
    end else if (pll_on && target_sel.freq == FREQ_HF_8M) begin
      target_sel.src = SRC_PLL;
    end
    cur_level = level_of(active_sel.src, osc_level_i);
    new_level = level_of(target_sel.src, osc_level_i);
    cur_prev  = level_of(active_sel.src, osc_prev);
    new_prev  = level_of(target_sel.src, osc_prev);
    next_pll_out = pll_on;
  end

  // Switch sequencer: next values
  always_comb begin
    next_state      = state;
    next_active_sel = active_sel;
    next_wait_cnt   = wait_cnt;
    next_osc_status = osc_status;
    next_clk_out    = cur_level;
    unique case (state)
      ST_RUN: begin
        if (cfg_valid && target_sel != active_sel) begin
          if ((src_bit(target_sel.src) & osc_status) == 6'h00) begin
            next_state    = ST_STARTUP;
            next_wait_cnt = 16'(STARTUP_CYCLES - 1);
          end else begin
            next_state    = ST_WAIT_FALL;
          end
        end
      end
      ST_STARTUP: begin
        if (wait_cnt == 16'h0000) begin
          next_state = ST_WAIT_FALL;
        end else begin
          next_wait_cnt = wait_cnt - 16'h0001;
        end
      end
      ST_WAIT_FALL: begin
        if (cur_prev && !cur_level) begin
          next_state   = ST_HOLD_LOW;
          next_clk_out = 1'b0;
        end
      end
      ST_HOLD_LOW: begin
        next_clk_out = 1'b0;
        if (!new_prev && new_level) begin
          next_active_sel = target_sel;
          next_clk_out    = 1'b1;
          next_osc_status = src_bit(target_sel.src);
          next_state      = ST_RUN;
        end
      end
    endcase
  end

  // Switch sequencer: registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state      <= ST_RUN;
      active_sel <= '{src: SRC_MF, freq: CTRL_RESET[CTRL_FREQ_LSB +: 4]};
      wait_cnt   <= 16'h0000;
      osc_status <= 6'h02;
      clk_out    <= 1'b0;
      osc_prev   <= '0;
      pll_out    <= 1'b0;
    end else if (clk_en_i) begin
      state      <= next_state;
      active_sel <= next_active_sel;
      wait_cnt   <= next_wait_cnt;
      osc_status <= next_osc_status;
      clk_out    <= next_clk_out;
      osc_prev   <= osc_level_i;
      pll_out    <= next_pll_out;
    end
  end

  // Register slave: next values
  always_comb begin
    next_ctrl    = ctrl;
    next_aw_full = aw_full | (s_axi_awvalid_i & awready);
    next_w_full  = w_full | (s_axi_wvalid_i & wready);
    next_aw_addr = (s_axi_awvalid_i & awready) ? s_axi_awaddr_i : aw_addr;
    next_w_data  = (s_axi_wvalid_i & wready) ? s_axi_wdata_i : w_data;
    next_w_strb  = (s_axi_wvalid_i & wready) ? s_axi_wstrb_i : w_strb;
    next_bvalid  = bvalid & ~s_axi_bready_i;
    next_bresp   = bresp;
    next_rvalid  = rvalid & ~s_axi_rready_i;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (aw_full && w_full && !bvalid) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (aw_addr[7:2] == OSC_CTRL_ADDR[7:2]) begin
        if (w_strb[0]) begin
          next_ctrl = w_data[7:0] & CTRL_WR_MASK;
        end
      end else if (aw_addr[7:2] != OSC_STAT_ADDR[7:2]) begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (s_axi_arvalid_i && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (s_axi_araddr_i[7:2] == OSC_CTRL_ADDR[7:2]) begin
        next_rdata[7:0] = ctrl;
      end else if (s_axi_araddr_i[7:2] == OSC_STAT_ADDR[7:2]) begin
        next_rdata[5:0]  = osc_status;
        next_rdata[6]    = (state != ST_RUN);
        next_rdata[7]    = cfg_pll;
        next_rdata[10:8] = cfg_osc;
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
    next_awready = ~next_aw_full & ~next_bvalid;
    next_wready  = ~next_w_full & ~next_bvalid;
    next_arready = ~next_rvalid;
  end

  // Register slave: registers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl    <= CTRL_RESET;
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (clk_en_i) begin
      ctrl    <= next_ctrl;
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // Outputs straight from flip-flops
  assign sys_clk_o       = clk_out;
  assign pll_enable_o    = pll_out;
  assign s_axi_awready_o = awready;
  assign s_axi_wready_o  = wready;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign s_axi_arready_o = arready;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;

endmodule : iosw_top

`default_nettype wire

/* File: tb/iosw_assertions.sv */
// Port-level checks for the oscillator switch top.
// Bound to iosw_top from the testbench top file.
`timescale 1ns/10ps
`default_nettype none
module iosw_assertions
  import iosw_pkg::*;
(
  // Clock, reset, enable
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        clk_en_i,
  // Configuration and clocks
  input wire logic        cfg_pll_enable_i,
  input wire iosw_osc_t   osc_level_i,
  input wire logic        sys_clk_o,
  input wire logic        pll_enable_o,
  // Register bus
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i || !clk_en_i);

  // Config PLL bit as captured on the first enabled edge after reset
  logic first;
  logic cfg_q;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      first <= 1'b1;
      cfg_q <= 1'b0;
    end else if (clk_en_i && first) begin
      first <= 1'b0;
      cfg_q <= cfg_pll_enable_i;
    end
  end

  // Both write channels taken at one edge
  sequence s_wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence

  AST_WR_RESP: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid_o)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp dropped");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata dropped");
  AST_RD_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
    s_axi_rvalid_o) else $error("read answer late");
  AST_AR_BLK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  AST_AW_BLK: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o) else $error("write taken early");
  AST_CFG_PLL: assert property (!first && cfg_q |=> pll_enable_o)
    else $error("config PLL not forcing PLL on");
  AST_CLK_LOW: assert property (osc_level_i == '0 |=> !sys_clk_o)
    else $error("system clock high with all sources low");
endmodule : iosw_assertions
`default_nettype wire

/* File: tb/iosw_top_tb.sv */
// Testbench for the oscillator switch: registers, routing, switch timing.
// Assumes iosw_pkg, iosw_top and iosw_assertions are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end
module iosw_top_tb
  import iosw_pkg::*;
;
  localparam int unsigned SU = 60;  // Shortened start-up count
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        clk_en_i = 1'b1;
  logic [2:0]  cfg_osc_select_i = FOSC_INT_BLOCK;
  logic        cfg_pll_enable_i = 1'b0;
  iosw_osc_t   osc_level_i;
  logic        sys_clk_o, pll_enable_o;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic        s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic        s_axi_rready_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [4:0]  cnt = 5'h00;
  int          errors = 0, comparisons = 0, cyc = 0;

  iosw_top #(.STARTUP_CYCLES(SU)) dut (
    .ref_clk_i, .sys_rst_i, .clk_en_i, .cfg_osc_select_i, .cfg_pll_enable_i,
    .osc_level_i, .sys_clk_o, .pll_enable_o,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o,
    .s_axi_rresp_o
  );

  initial forever #5 ref_clk_i = ~ref_clk_i;
  // Oscillator levels of different rates, plus a hang limit
  always @(posedge ref_clk_i) begin
    cnt <= cnt + 5'h01;
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      end_sim();
    end
  end
  always_comb osc_level_i = {cnt[1], cnt[3], cnt[0], cnt[1], cnt[2], cnt[4]};

  task automatic end_sim;
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // Reset for five cycles, then let two edges pass
  task automatic rst;
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask : rst

  // Bus write; both channels offered together, response checked
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge ref_clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    // Accept the answer one edge late so the slave has to hold it
    s_axi_bready_i <= 1'b1;
    @(posedge ref_clk_i);
    `CHK({s_axi_bvalid_o, s_axi_bresp_o}, {1'b1, r})
    s_axi_bready_i <= 1'b0;
  endtask : wr

  // Bus read
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge ref_clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    // Accept the answer one edge late so the slave has to hold it
    s_axi_rready_i <= 1'b1;
    @(posedge ref_clk_i);
    `CHK(s_axi_rvalid_o, 1'b1)
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask : rd

  function automatic logic [31:0] st(input logic [5:0] s);
    return {21'h0, cfg_osc_select_i, cfg_pll_enable_i, 1'b0, s};
  endfunction : st

  // Poll status until the switch is no longer busy; n is cycles taken
  task automatic idle(output int n);
    int t0;
    logic [31:0] d;
    logic [1:0] r;
    t0 = cyc;
    do rd(OSC_STAT_ADDR, d, r); while (d[6] !== 1'b0);
    n = cyc - t0;
  endtask : idle

  // Write control, wait for the switch, check active sources
  task automatic sw(input logic [7:0] c, input logic [5:0] s, output int n);
    logic [31:0] d;
    logic [1:0] r;
    wr(OSC_CTRL_ADDR, {24'h0, c}, RESP_OKAY);
    idle(n);
    rd(OSC_STAT_ADDR, d, r);
    `CHK(d, st(s))
  endtask : sw

  // Routed clock tracks the chosen source's level one cycle behind
  task automatic follow(input iosw_src_t s);
    logic lv;
    repeat (16) begin
      lv = osc_level_i[s];
      @(posedge ref_clk_i);
      `CHK(sys_clk_o, lv)
    end
  endtask : follow

  // Clock enable low freezes the routed clock
  task automatic t_hold;
    logic s;
    clk_en_i <= 1'b0;
    @(posedge ref_clk_i);
    s = sys_clk_o;
    repeat (6) begin
      @(posedge ref_clk_i);
      `CHK(sys_clk_o, s)
    end
    clk_en_i <= 1'b1;
  endtask : t_hold

  // Reset values, read-only status, unmapped addresses
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(OSC_CTRL_ADDR, d, r);
    `CHK(d, {24'h0, CTRL_RESET})
    `CHK(pll_enable_o, 1'b0)
    wr(OSC_STAT_ADDR, 32'hffffffff, RESP_OKAY);
    rd(OSC_STAT_ADDR, d, r);
    `CHK(d, st(6'h02))
    rd(8'h08, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    wr(8'h0c, 32'h0, RESP_SLVERR);
  endtask : t_reset

  // Frequency codes, with start-up only when leaving the active source
  task automatic t_freq;
    logic [3:0] cd [6] = '{4'hf, 4'hd, 4'h7, 4'h2, 4'h0, 4'h3};
    logic [5:0] sc [6] = '{6'h04, 6'h04, 6'h02, 6'h02, 6'h01, 6'h04};
    logic [5:0] slow = 6'h35;
    int n;
    for (int i = 0; i < 6; i++) begin
      sw({1'b0, cd[i], 3'b010}, sc[i], n);
      `CHK(n > 50, slow[i])
    end
  endtask : t_freq

  // PLL routing against the system select field
  task automatic t_pll;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    sw(8'hf7, 6'h04, n);
    rd(OSC_CTRL_ADDR, d, r);
    `CHK(d, 32'hf3)
    `CHK(pll_enable_o, 1'b1)
    sw(8'hf0, 6'h0c, n);
    follow(SRC_PLL);
    sw(8'hf1, 6'h10, n);
    follow(SRC_TIMER);
    sw(8'h70, 6'h04, n);
    `CHK(pll_enable_o, 1'b0)
  endtask : t_pll

  // Configuration word forcing the PLL, then an external source
  task automatic t_cfg;
    int n;
    cfg_pll_enable_i <= 1'b1;
    rst();
    sw(8'h70, 6'h0c, n);
    `CHK(pll_enable_o, 1'b1)
    cfg_osc_select_i <= 3'h2;
    cfg_pll_enable_i <= 1'b0;
    rst();
    sw(8'hf0, 6'h20, n);
    follow(SRC_EXT);
  endtask : t_cfg

  initial begin
    rst();
    t_reset();
    t_freq();
    t_pll();
    t_hold();
    t_cfg();
    end_sim();
  end
endmodule : iosw_top_tb

bind iosw_top iosw_assertions chk (
  .ref_clk_i, .sys_rst_i, .clk_en_i, .cfg_pll_enable_i, .osc_level_i,
  .sys_clk_o, .pll_enable_o, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .s_axi_rdata_o
);
`default_nettype wire
